// ---- hw/intc_cmd_status.v ----
// Command and status registers of a vectored interrupt controller with APB slave
`timescale 1ns/1ps
`include "intc_cmd_regs.vh"
module intc_cmd_status #(
	parameter NSRC = 32
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [11:0]      paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output reg              pready,
	output reg              pslverr,
	input  wire [NSRC-1:0]  src_in,
	output reg              fast_request_line_n,
	output reg              normal_request_line_n,
	output reg              end_of_service,
	output reg              protection_mode,
	output reg              irq
);

	reg  [31:0] src_s1_r;
	reg  [31:0] src_s2_r;
	reg  [31:0] enabled_r;
	reg  [31:0] pending_r;
	reg  [31:0] ff_r;
	reg  [31:0] spurious_r;
	reg  [31:0] vector_r;
	reg  [4:0]  cur_src_r;
	reg         cur_valid_r;
	reg         global_mask_r;
	reg         ev_spur_n;
	reg         ev_spur_f;
	reg  [`EV_WIDTH-1:0] ev_stat_r;
	reg  [`EV_WIDTH-1:0] ev_mask_r;
	reg  [`EV_WIDTH-1:0] ev_set;
	wire [31:0] src_w;
	wire        wr_fire;
	wire        rd_fire;
	wire [31:0] active;
	wire [31:0] fast_active;
	wire [31:0] normal_active;
	wire        fast_req;
	wire        normal_req;
	reg  [31:0] rd_nxt;
	reg         err_nxt;
	integer     i;

	// Lowest active source number; fixed priority stands in for arbitration
	function [4:0] first_set;
		input [31:0] v;
		integer k;
		begin
			first_set = 5'h00;
			for (k = 31; k >= 0; k = k - 1) begin
				if (v[k])
					first_set = k[4:0];
			end
		end
	endfunction

	// Address decode shared by reads and writes
	function is_ofs;
		input [11:0] a;
		input [11:0] o;
		begin
			is_ofs = (a == o);
		end
	endfunction

	generate
		if (NSRC < 32) begin : g_pad
			assign src_w = {{(32-NSRC){1'b0}}, src_s2_r[NSRC-1:0]};
		end else begin : g_full
			assign src_w = src_s2_r;
		end
	endgenerate

	assign wr_fire       = psel & penable & pwrite & pready;
	assign rd_fire       = psel & penable & ~pwrite & pready;
	assign active        = pending_r & enabled_r;
	assign fast_active   = active & ({ff_r[31:1], 1'b1});
	assign normal_active = active & ~({ff_r[31:1], 1'b1});
	assign fast_req      = (|fast_active) & ~global_mask_r; // RULE12
	assign normal_req    = (|normal_active) & ~global_mask_r & ~cur_valid_r; // RULE12

	// Source inputs come from other clock domains
	always @(posedge clk) begin
		if (srst) begin
			src_s1_r <= 32'h00000000;
			src_s2_r <= 32'h00000000;
		end else begin
			src_s1_r[NSRC-1:0] <= src_in;
			src_s2_r           <= src_s1_r;
		end
	end

	// Source enable, pending, fast forcing and debug state
	always @(posedge clk) begin
		if (srst) begin
			enabled_r     <= `RST_WORD;
			pending_r     <= `RST_WORD;
			ff_r          <= `RST_WORD;
			spurious_r    <= `RST_WORD;
			global_mask_r <= 1'b0;
			protection_mode <= 1'b0;
		end else begin
			// Set beats clear: a source level still high in the clear cycle keeps it pending
			for (i = 0; i < 32; i = i + 1) begin
				if (src_w[i] | (wr_fire & is_ofs(paddr, `OFS_SET_CMD) & pwdata[i])) // RULE3 RULE7
					pending_r[i] <= 1'b1;
				else if (wr_fire & is_ofs(paddr, `OFS_CLEAR_CMD) & pwdata[i]) // RULE6
					pending_r[i] <= 1'b0;
				else if (rd_fire & is_ofs(paddr, `OFS_NORMAL_VECTOR) & cur_valid_r == 1'b0 &
					|normal_active & first_set(normal_active) == i[4:0] & ~protection_mode)
					pending_r[i] <= 1'b0;
			end
			if (wr_fire & is_ofs(paddr, `OFS_ENABLE_CMD))
				enabled_r <= enabled_r | pwdata; // RULE4
			if (wr_fire & is_ofs(paddr, `OFS_DISABLE_CMD))
				enabled_r <= enabled_r & ~pwdata; // RULE5
			if (wr_fire & is_ofs(paddr, `OFS_FF_ENABLE))
				ff_r <= (ff_r | pwdata) & `FF_VALID_MASK; // RULE13 RULE18
			if (wr_fire & is_ofs(paddr, `OFS_FF_DISABLE))
				ff_r <= ff_r & ~pwdata & `FF_VALID_MASK; // RULE14
			if (wr_fire & is_ofs(paddr, `OFS_SPURIOUS))
				spurious_r <= pwdata; // RULE9
			if (wr_fire & is_ofs(paddr, `OFS_DEBUG)) begin
				protection_mode <= pwdata[`BIT_PROTECTION]; // RULE11
				global_mask_r   <= pwdata[`BIT_GLOBAL_MASK]; // RULE12
			end
		end
	end

	// Current normal interrupt, taken on a vector read and released by end of service
	always @(posedge clk) begin
		if (srst) begin
			cur_valid_r <= 1'b0;
			cur_src_r   <= 5'h00;
			vector_r    <= `RST_WORD;
		end else begin
			if (wr_fire & is_ofs(paddr, `OFS_END_SERVICE))
				cur_valid_r <= 1'b0; // RULE8
			else if (rd_fire & is_ofs(paddr, `OFS_NORMAL_VECTOR) & ~cur_valid_r & |normal_active) begin
				cur_valid_r <= 1'b1;
				cur_src_r   <= first_set(normal_active);
			end
		end
	end

	// Both vector reads always hand back the spurious address, current interrupt or not
	always @* begin
		ev_spur_n = 1'b0;
		ev_spur_f = 1'b0;
		err_nxt   = 1'b0;
		rd_nxt    = 32'h00000000;
		case (paddr)
			`OFS_NORMAL_VECTOR: begin
				rd_nxt    = spurious_r; // RULE9 RULE16
				ev_spur_n = ~cur_valid_r & ~(|normal_active);
			end
			`OFS_FAST_VECTOR: begin
				rd_nxt    = spurious_r; // RULE10
				ev_spur_f = ~(|fast_active);
			end
			`OFS_CURRENT_SOURCE: rd_nxt = {27'h0000000, cur_src_r};
			`OFS_PENDING:        rd_nxt = pending_r;
			`OFS_MASK:           rd_nxt = enabled_r; // RULE17
			`OFS_CORE_STATUS: begin
				rd_nxt[`BIT_FAST_LINE_STATE]   = ~fast_request_line_n; // RULE1
				rd_nxt[`BIT_NORMAL_LINE_STATE] = ~normal_request_line_n; // RULE2
			end
			`OFS_SPURIOUS:       rd_nxt = spurious_r;
			`OFS_DEBUG:          rd_nxt = {30'h00000000, global_mask_r, protection_mode}; // RULE18
			`OFS_FF_STATUS:      rd_nxt = ff_r & `FF_VALID_MASK; // RULE15 RULE18
			`OFS_IRQ_STATUS:     rd_nxt = {29'h00000000, ev_stat_r};
			`OFS_IRQ_MASK:       rd_nxt = {29'h00000000, ev_mask_r};
			`OFS_ENABLE_CMD, `OFS_DISABLE_CMD, `OFS_CLEAR_CMD, `OFS_SET_CMD,
			`OFS_END_SERVICE, `OFS_FF_ENABLE, `OFS_FF_DISABLE: rd_nxt = 32'h00000000;
			default:             err_nxt = 1'b1;
		endcase
	end

	always @* begin
		ev_set = {`EV_WIDTH{1'b0}};
		ev_set[`EV_END_SERVICE]     = wr_fire & is_ofs(paddr, `OFS_END_SERVICE);
		ev_set[`EV_SPURIOUS_NORMAL] = rd_fire & ev_spur_n;
		ev_set[`EV_SPURIOUS_FAST]   = rd_fire & ev_spur_f;
	end

	// APB: no wait state, read data registered at the edge that ends the setup phase
	always @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & err_nxt;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h00000000;
		end
	end

	// Event status: write one to clear, new event wins
	always @(posedge clk) begin
		if (srst) begin
			ev_stat_r <= {`EV_WIDTH{1'b0}};
			ev_mask_r <= {`EV_WIDTH{1'b0}};
			irq       <= 1'b0;
		end else begin
			if (wr_fire & is_ofs(paddr, `OFS_IRQ_MASK))
				ev_mask_r <= pwdata[`EV_WIDTH-1:0];
			if (wr_fire & is_ofs(paddr, `OFS_IRQ_STATUS))
				ev_stat_r <= (ev_stat_r & ~pwdata[`EV_WIDTH-1:0]) | ev_set;
			else
				ev_stat_r <= ev_stat_r | ev_set;
			irq <= |(ev_stat_r & ev_mask_r);
		end
	end

	// Request lines are active low towards the core
	always @(posedge clk) begin
		if (srst) begin
			fast_request_line_n   <= 1'b1;
			normal_request_line_n <= 1'b1;
			end_of_service        <= 1'b0;
		end else begin
			fast_request_line_n   <= ~fast_req; // RULE12
			normal_request_line_n <= ~normal_req; // RULE12
			end_of_service        <= wr_fire & is_ofs(paddr, `OFS_END_SERVICE); // RULE8
		end
	end

endmodule

// ---- include/intc_cmd_regs.vh ----
// Register offsets, field positions and reset values of the interrupt command/status block
// Summary of operation
// RULE1: Core status bit 0 shows fast request line asserted (1) or inactive (0).
// RULE2: Core status bit 1 shows normal request line asserted (1) or inactive (0).
// RULE3: Source bit map: fast at bit 0, system at bit 1, peripherals 2..31.
// RULE4: Writing ones to enable command enables those sources; zeros change nothing.
// RULE5: Writing ones to disable command disables those sources; zeros change nothing.
// RULE6: Writing ones to clear command clears those pending interrupts; zeros change nothing.
// RULE7: Writing ones to set command sets those pending interrupts; zeros change nothing.
// RULE8: Any write to end-of-service register signals completion, whatever the data.
// RULE9: Normal vector read returns the stored spurious address on a spurious normal interrupt.
// RULE10: Fast vector read returns the stored spurious address on a spurious fast interrupt.
// RULE11: Debug protection bit enables protection mode when 1; read/write, resets to zero.
// RULE12: Global mask bit at 1 forces both request lines inactive.
// RULE13: Writing ones to fast forcing enable turns forcing on; bit 0 reserved.
// RULE14: Writing ones to fast forcing disable turns forcing off; zeros change nothing.
// RULE15: Fast forcing status reads 1 where forcing is enabled, 0 elsewhere.
// RULE16: With no current interrupt, normal vector read returns the spurious address.
// RULE17: Mask readback shows 1 for enabled sources and 0 for disabled ones.
// RULE18: Reserved bits ignore writes and read as zero, fast forcing bit 0 included.
`ifndef INTC_CMD_REGS_VH
`define INTC_CMD_REGS_VH
`define OFS_NORMAL_VECTOR    12'h100
`define OFS_FAST_VECTOR      12'h104
`define OFS_CURRENT_SOURCE   12'h108
`define OFS_PENDING          12'h10C
`define OFS_MASK             12'h110
`define OFS_CORE_STATUS      12'h114
`define OFS_ENABLE_CMD       12'h120
`define OFS_DISABLE_CMD      12'h124
`define OFS_CLEAR_CMD        12'h128
`define OFS_SET_CMD          12'h12C
`define OFS_END_SERVICE      12'h130
`define OFS_SPURIOUS         12'h134
`define OFS_DEBUG            12'h138
`define OFS_FF_ENABLE        12'h140
`define OFS_FF_DISABLE       12'h144
`define OFS_FF_STATUS        12'h148
`define OFS_IRQ_STATUS       12'h150
`define OFS_IRQ_MASK         12'h154
`define BIT_FAST_SOURCE      0
`define BIT_SYSTEM_SOURCE    1
`define BIT_PROTECTION       0
`define BIT_GLOBAL_MASK      1
`define BIT_FAST_LINE_STATE  0
`define BIT_NORMAL_LINE_STATE 1
`define FF_VALID_MASK        32'hFFFFFFFE
`define RST_WORD             32'h00000000
`define EV_END_SERVICE       0
`define EV_SPURIOUS_NORMAL   1
`define EV_SPURIOUS_FAST     2
`define EV_WIDTH             3
`endif

// ---- verification/core_model.sv ----
// Core-side model sampling the active-low request lines
`timescale 1ns/1ps
module core_model (
	input  logic clk,
	input  logic fast_request_line_n,
	input  logic normal_request_line_n,
	output logic fast_seen,
	output logic normal_seen
);
	// Sampled on the same clock that registers the lines, so every level is seen one cycle later
	always_ff @(posedge clk) begin
		fast_seen   <= ~fast_request_line_n;
		normal_seen <= ~normal_request_line_n;
	end
endmodule

// ---- verification/intc_cmd_status_chk.sv ----
// Port checker for the interrupt command and status block
`timescale 1ns/1ps
module intc_chk (
	input logic        clk,
	input logic        srst,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        fast_request_line_n,
	input logic        normal_request_line_n,
	input logic        end_of_service,
	input logic        protection_mode,
	input logic        irq
);
	wire acc  = psel && penable && pready && pwrite;
	wire eosw = acc && paddr == 12'h130;
	wire dbgw = acc && paddr == 12'h138;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
	a_eos_pulse: assert property (eosw |=> end_of_service ##1 !end_of_service)
		else $error("end of service pulse wrong");
	a_eos_cause: assert property (end_of_service |-> $past(eosw)) else $error("stray end of service");
	a_protection_mode_bit_follow: assert property (dbgw |=> protection_mode == $past(pwdata[0]))
		else $error("protection mode not written");
	a_reset_idle: assert property ($fell(srst) |-> fast_request_line_n && normal_request_line_n && !irq)
		else $error("outputs not idle after reset");
	c_eos: cover property (eosw);
	c_dbg: cover property (dbgw);
	c_err: cover property (pslverr);
endmodule
bind intc_cmd_status intc_chk u_chk (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .fast_request_line_n, .normal_request_line_n, .end_of_service, .protection_mode, .irq);

// ---- verification/tb_top.sv ----
// Self-checking bench for the interrupt command and status block
`timescale 1ns/1ps
`define CHK(nm, x, g) begin samples_checked++; if ((g) !== (x)) begin err_total++; \
	$display("MISMATCH %s expected %h seen %h", nm, x, g); end end
module tb_top;
	logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, src_in = 32'h0, q;
	wire  [31:0] prdata;
	wire         pready, pslverr, fln, nln, eos, protection_mode_bit, irq, fs, ns;
	int          err_total = 0, samples_checked = 0;
	logic [87:0] rows [8] = '{{12'h120, 32'h00000F0F, 12'h110, 32'h00000F0F},
		{12'h124, 32'h00000003, 12'h110, 32'h00000F0C}, {12'h12C, 32'h80000004, 12'h10C, 32'h80000004},
		{12'h128, 32'h80000000, 12'h10C, 32'h00000004}, {12'h140, 32'hFFFFFFFF, 12'h148, 32'hFFFFFFFE},
		{12'h144, 32'h00000002, 12'h148, 32'hFFFFFFFC}, {12'h134, 32'h12345678, 12'h104, 32'h12345678},
		{12'h138, 32'hFFFFFFFE, 12'h138, 32'h00000002}};
	initial forever #5 clk = ~clk;
	intc_cmd_status DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.src_in, .fast_request_line_n(fln), .normal_request_line_n(nln), .end_of_service(eos),
		.protection_mode(protection_mode_bit), .irq);
	core_model core (.clk, .fast_request_line_n(fln), .normal_request_line_n(nln), .fast_seen(fs), .normal_seen(ns));
	task end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// Bounded wait: a slave that never answers ends the run
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1) begin
			err_total++;
			end_of_test;
		end
	endtask
	task rc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK("read", x, q)
	endtask
	task wl(input logic [2:0] x);
		for (int n = 0; n < 20 && {irq, ns, fs} !== x; n++)
			@(posedge clk);
		`CHK("irq_lines", x, {irq, ns, fs})
	endtask
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, rows[i][87:76], rows[i][75:44]);
			rc(rows[i][43:32], rows[i][31:0]);
		end
		wl(3'b000);
		rc(12'h114, 32'h0);
		apb(1'b1, 12'h138, 32'h0);
		wl(3'b001);
		rc(12'h114, 32'h1);
		apb(1'b1, 12'h144, 32'hFFFFFFFE);
		wl(3'b010);
		rc(12'h114, 32'h2);
		rc(12'h100, 32'h12345678);
		wl(3'b000);
		apb(1'b1, 12'h130, 32'hDEADBEEF);
		@(posedge clk);
		`CHK("end_of_service", 1'b1, eos)
		rc(12'h150, 32'h1);
		wl(3'b000);
		apb(1'b1, 12'h154, 32'h1);
		wl(3'b100);
		apb(1'b1, 12'h150, 32'h1);
		wl(3'b000);
		apb(1'b0, 12'hFFC, 32'h0);
		`CHK("unmapped", 33'h100000000, {e, q})
		apb(1'b1, 12'h138, 32'h1);
		@(posedge clk);
		`CHK("protection_mode_bit", 1'b1, protection_mode_bit)
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rc(12'h138, 32'h0);
		rc(12'h134, 32'h0);
		`CHK("protection_mode_bit", 1'b0, protection_mode_bit)
		// Source level passes two sync flops before it reaches pending
		src_in <= 32'h00000008;
		repeat (4) @(posedge clk);
		src_in <= 32'h00000000;
		rc(12'h10C, 32'h00000008);
		repeat (3) @(posedge clk);
		apb(1'b1, 12'h128, 32'h00000008);
		rc(12'h10C, 32'h00000000);
		end_of_test;
	end
endmodule
